// file: core/nv_seq_pkg.sv
// Constants and types for the nonvolatile store/recall sequencer
package nv_seq_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLK_NS          = 40;
  localparam int unsigned POWERUP_MS_HI   = 20;
  localparam int unsigned POWERUP_MS_LO   = 40;
  localparam int unsigned STORE_MS        = 8;
  localparam int unsigned GRACE_NS        = 25;
  localparam int unsigned SLEEP_MS        = 8;
  localparam int unsigned STANDBY_US      = 100;
  localparam int unsigned SOFT_SEQ_US     = 500;
  localparam int unsigned RECALL_US       = 600;
  localparam int unsigned ACTIVE_US       = 5;
  localparam int unsigned DRIVE_HI_NS     = 500;
  // Nanosecond times round down; only the grace time is held to at least one cycle
  localparam int unsigned CYC_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_US = CLK_HZ / 1_000_000;
  localparam int unsigned POWERUP_CYC_HI  = POWERUP_MS_HI * CYC_MS;
  localparam int unsigned POWERUP_CYC_LO  = POWERUP_MS_LO * CYC_MS;
  localparam int unsigned STORE_CYC       = STORE_MS * CYC_MS;
  localparam int unsigned GRACE_CYC =
    (GRACE_NS / CLK_NS) < 1 ? 1 : GRACE_NS / CLK_NS;
  localparam int unsigned SLEEP_CYC       = SLEEP_MS * CYC_MS;
  localparam int unsigned STANDBY_CYC     = STANDBY_US * CYC_US;
  localparam int unsigned SOFT_SEQ_CYC    = SOFT_SEQ_US * CYC_US;
  localparam int unsigned RECALL_CYC      = RECALL_US * CYC_US;
  localparam int unsigned ACTIVE_CYC      = ACTIVE_US * CYC_US;
  localparam int unsigned DRIVE_HI_CYC    = DRIVE_HI_NS / CLK_NS;
  localparam int unsigned CNT_W           = 21;

  typedef enum logic [7:0] {
    ST_RESTORE = 8'h01,
    ST_READY   = 8'h02,
    ST_GRACE   = 8'h04,
    ST_SAVE    = 8'h08,
    ST_RECALL  = 8'h10,
    ST_SLEEPG  = 8'h20,
    ST_SLEEP   = 8'h40,
    ST_WAKE    = 8'h80
  } seq_state_t;

  typedef struct packed {
    logic soft_save;
    logic soft_recall;
    logic sleep;
    logic wake;
  } soft_cmd_t;

  typedef struct packed {
    logic access_en;
    logic write_en;
    logic busy;
    logic standby;
    logic asleep;
  } seq_status_t;
endpackage : nv_seq_pkg

// file: core/nv_down_counter.sv
// Loadable down counter with terminal flag
`timescale 1ns/1ps
module nv_down_counter
  import nv_seq_pkg::*;
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_value,
  output logic                  o_zero
);
  logic [CNT_W-1:0] cnt_r;
  assign o_zero = (cnt_r == '0);
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      cnt_r <= '0;
    else if (i_load)
      cnt_r <= i_value;
    else if (!o_zero)
      cnt_r <= cnt_r - 1'b1;
  end
endmodule : nv_down_counter

// file: core/nv_store_recall_sequencer.sv
// Store/recall, sleep and store-busy pin sequencer
`timescale 1ns/1ps
module nv_store_recall_sequencer
  import nv_seq_pkg::*;
(
  input  wire logic      i_clk_sys,
  input  wire logic      i_sys_rst,
  input  wire logic      i_low_variant,
  input  wire logic      i_supply_ok,
  input  wire logic      i_sram_write,
  input  wire logic      i_bus_stop,
  input  wire logic      i_bus_busy,
  input  wire soft_cmd_t i_cmd,
  input  wire logic      i_store_busy_pin_in,
  output logic           o_store_busy_pin_out,
  output logic           o_store_busy_pin_oe,
  output seq_status_t    o_status
);
  seq_state_t       state_r;
  seq_state_t       state_nxt;
  logic             dirty_r;
  logic             pin_low_r;
  logic             drive_hi_r;
  logic             resume_r;
  logic             standby_r;
  logic             cmd_pend_r;
  soft_cmd_t        cmd_r;
  logic [CNT_W-1:0] sb_cnt_r;
  logic [CNT_W-1:0] load_val;
  logic             load;
  logic             tmr_zero;
  logic             hb_load;
  logic             hb_zero;
  logic             pin_req;
  logic             pin_rise;
  logic             power_fail;
  logic             in_ready;
  logic             save_need;
  logic [CNT_W-1:0] wake_cyc;
  seq_status_t      status_nxt;

  nv_down_counter u_step_timer (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_load    (load),
    .i_value   (load_val),
    .o_zero    (tmr_zero)
  );

  nv_down_counter u_drive_timer (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_load    (hb_load),
    .i_value   (CNT_W'(DRIVE_HI_CYC)),
    .o_zero    (hb_zero)
  );

  assign wake_cyc   = i_low_variant ? CNT_W'(POWERUP_CYC_LO)
                                    : CNT_W'(POWERUP_CYC_HI);
  assign power_fail = !i_supply_ok;
  assign in_ready   = (state_r == ST_READY);
  // External low only counts while we are not driving the pin
  assign pin_req    = !i_store_busy_pin_in && !o_store_busy_pin_oe;
  assign pin_rise   = pin_low_r && i_store_busy_pin_in;
  assign save_need  = dirty_r || i_sram_write;

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    load      = 1'b0;
    load_val  = '0;
    case (state_r)
      ST_RESTORE:
      begin
        if (power_fail)
        begin
          load      = 1'b1;
          load_val  = wake_cyc;
        end
        else if (tmr_zero)
          state_nxt = ST_READY;
      end
      ST_READY:
      begin
        if ((power_fail || pin_req) && save_need)
        begin
          state_nxt = ST_GRACE;
          load      = 1'b1;
          load_val  = CNT_W'(GRACE_CYC);
        end
        else if (cmd_pend_r && cmd_r.soft_save)
        begin
          state_nxt = ST_SAVE;
          load      = 1'b1;
          load_val  = CNT_W'(STORE_CYC);
        end
        else if (cmd_pend_r && cmd_r.soft_recall)
        begin
          state_nxt = ST_RECALL;
          load      = 1'b1;
          load_val  = CNT_W'(RECALL_CYC);
        end
        else if (cmd_pend_r && cmd_r.sleep)
        begin
          state_nxt = ST_SLEEPG;
          load      = 1'b1;
          load_val  = save_need ? CNT_W'(STORE_CYC) : CNT_W'(1);
        end
      end
      ST_GRACE:
        if (tmr_zero)
        begin
          state_nxt = ST_SAVE;
          load      = 1'b1;
          load_val  = CNT_W'(STORE_CYC);
        end
      ST_SAVE:
        if (tmr_zero)
          state_nxt = ST_READY;
      ST_RECALL:
        if (tmr_zero)
          state_nxt = ST_READY;
      ST_SLEEPG:
        if (tmr_zero)
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        if (i_cmd.wake)
        begin
          state_nxt = ST_WAKE;
          load      = 1'b1;
          load_val  = wake_cyc;
        end
      ST_WAKE:
        if (tmr_zero)
          state_nxt = ST_READY;
      default:
      begin
        state_nxt = ST_RESTORE;
        load      = 1'b1;
        load_val  = wake_cyc;
      end
    endcase
  end

  assign hb_load = pin_rise || (state_r == ST_SAVE && tmr_zero);

  // Outputs
  always_comb
  begin
    status_nxt           = '0;
    status_nxt.access_en = in_ready && i_supply_ok && !pin_low_r
                           && !pin_req && !resume_r;
    status_nxt.write_en  = status_nxt.access_en
                           || (state_r == ST_GRACE);
    status_nxt.busy      = (state_r != ST_READY);
    status_nxt.standby   = standby_r;
    status_nxt.asleep    = (state_nxt == ST_SLEEP);
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_r <= ST_RESTORE;
    else
      state_r <= state_nxt;
  end

  // Pin state, resume window, dirty flag
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      dirty_r    <= 1'b0;
      pin_low_r  <= 1'b0;
      resume_r   <= 1'b0;
    end
    else
    begin
      pin_low_r <= pin_req;
      if (pin_rise)
        resume_r <= 1'b1;
      else if (hb_zero)
        resume_r <= 1'b0;
      // A write in the clearing cycle is ignored, as write_en is low in save
      if (i_sram_write && status_nxt.write_en)
        dirty_r <= 1'b1;
      else if (state_r == ST_SAVE && tmr_zero)
        dirty_r <= 1'b0;
    end
  end

  // Soft command capture; taken only when idle
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cmd_r      <= '0;
      cmd_pend_r <= 1'b0;
    end
    else if (!cmd_pend_r && in_ready && i_supply_ok && (|i_cmd))
    begin
      cmd_r      <= i_cmd;
      cmd_pend_r <= 1'b1;
    end
    else if (state_r != ST_READY)
      cmd_pend_r <= 1'b0;
  end

  // Standby timer after stop
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sb_cnt_r  <= '0;
      standby_r <= 1'b0;
    end
    else if (i_bus_busy)
    begin
      sb_cnt_r  <= '0;
      standby_r <= 1'b0;
    end
    else if (i_bus_stop)
    begin
      sb_cnt_r  <= CNT_W'(STANDBY_CYC);
      standby_r <= 1'b0;
    end
    else if (sb_cnt_r == CNT_W'(1))
    begin
      sb_cnt_r  <= '0;
      standby_r <= 1'b1;
    end
    else if (sb_cnt_r != '0)
      sb_cnt_r <= sb_cnt_r - 1'b1;
  end

  // Store-busy pin drive
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_store_busy_pin_out <= 1'b1;
      o_store_busy_pin_oe  <= 1'b0;
      drive_hi_r           <= 1'b0;
      o_status             <= '0;
    end
    else
    begin
      o_status <= status_nxt;
      if (state_nxt == ST_SAVE)
      begin
        o_store_busy_pin_out <= 1'b0;
        o_store_busy_pin_oe  <= 1'b1;
        drive_hi_r           <= 1'b0;
      end
      else if (state_r == ST_SAVE)
      begin
        o_store_busy_pin_out <= 1'b1;
        o_store_busy_pin_oe  <= 1'b1;
        drive_hi_r           <= 1'b1;
      end
      else if (drive_hi_r && hb_zero)
      begin
        o_store_busy_pin_oe  <= 1'b0;
        drive_hi_r           <= 1'b0;
      end
    end
  end
endmodule : nv_store_recall_sequencer

// file: verification/nv_seq_assertions.sv
// Checker for the store/recall sequencer ports
`timescale 1ns/1ps
module nv_seq_assertions
  import nv_seq_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_sys_rst,
  input wire logic        i_low_variant,
  input wire logic        i_supply_ok,
  input wire logic        i_sram_write,
  input wire logic        i_bus_stop,
  input wire logic        i_bus_busy,
  input wire soft_cmd_t   i_cmd,
  input wire logic        i_store_busy_pin_in,
  input wire logic        o_store_busy_pin_out,
  input wire logic        o_store_busy_pin_oe,
  input wire seq_status_t o_status
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  localparam int REC_LIM = 12500;
  logic [3:0]  hi_r;
  logic [11:0] idle_r;
  logic [13:0] rec_r;
  // Cycles since a recall command was offered while idle
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) rec_r <= 14'h0000;
    else if (o_status.busy) rec_r <= 14'h0000;
    else if (rec_r != 14'h0000)
      rec_r <= (rec_r == 14'h3fff) ? rec_r : rec_r + 14'h0001;
    else if (i_cmd.soft_recall && o_status.access_en && i_supply_ok)
      rec_r <= 14'h0001;
  // Cycles the pin is driven high
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) hi_r <= 4'h0;
    else hi_r <= (o_store_busy_pin_oe && o_store_busy_pin_out) ?
                 hi_r + 4'h1 : 4'h0;
  // Quiet bus cycles since the last stop
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) idle_r <= 12'h000;
    else if (i_bus_busy || !o_status.access_en)
      idle_r <= 12'h000;
    else if (i_bus_stop)
      idle_r <= 12'h001;
    else if (idle_r != 12'h000 && idle_r != 12'hfff)
      idle_r <= idle_r + 12'h001;
  lock_access_a: assert property (o_status.busy |-> !o_status.access_en)
    else $error("access open while busy");
  supply_low_a: assert property (!i_supply_ok [*2] |-> !o_status.access_en)
    else $error("access open at low supply");
  pin_hold_a: assert property (!i_store_busy_pin_in [*3] |-> !o_status.access_en)
    else $error("access open while pin low");
  drive_high_a: assert property (hi_r <= 4'hc)
    else $error("pin driven high too long");
  release_high_a: assert property ($fell(o_store_busy_pin_oe) |-> $past(o_store_busy_pin_out))
    else $error("pin released from low");
  grace_end_a: assert property (o_store_busy_pin_oe && !o_store_busy_pin_out |-> ##[0:1] (o_status.busy && !o_status.write_en))
    else $error("writes open during save");
  resume_a: assert property ($rose(i_store_busy_pin_in) && !o_store_busy_pin_oe && !o_status.busy && !o_status.asleep && i_supply_ok |-> ##[1:125] o_status.access_en)
    else $error("no resume after pin rise");
  recall_start_a: assert property (rec_r <= REC_LIM)
    else $error("recall not taken");
  standby_a: assert property (idle_r == 12'h9c9 |-> o_status.standby)
    else $error("standby late");
  recall_c: cover property ($rose(o_status.busy) && !o_store_busy_pin_oe);
  standby_c: cover property ($rose(o_status.standby));
  save_c: cover property (o_store_busy_pin_oe && !o_store_busy_pin_out);
endmodule : nv_seq_assertions

bind nv_store_recall_sequencer nv_seq_assertions CHK (.i_clk_sys,
  .i_sys_rst, .i_low_variant, .i_supply_ok, .i_sram_write, .i_bus_stop,
  .i_bus_busy, .i_cmd, .i_store_busy_pin_in, .o_store_busy_pin_out,
  .o_store_busy_pin_oe, .o_status);

// file: verification/store_busy_agent.sv
// External store-busy driver and open-drain pin resolution
`timescale 1ns/1ps
module store_busy_agent
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_req,
  input  wire logic [3:0] i_len,
  input  wire logic       i_dev_out,
  input  wire logic       i_dev_oe,
  output logic            o_pin
);
  logic [3:0] low_r = 4'h0;
  // Pull low for a whole number of cycles, never shorter than one
  always @(negedge i_clk_sys)
    if (i_req) low_r <= (i_len == 4'h0) ? 4'h1 : i_len;
    else if (low_r != 4'h0) low_r <= low_r - 4'h1;
  // Low wins; pull-up when nobody drives
  assign o_pin = (low_r != 4'h0) ? 1'b0 : (i_dev_oe ? i_dev_out : 1'b1);
endmodule : store_busy_agent

// file: verification/nv_store_recall_sequencer_tb.sv
// Self-checking bench for the store/recall sequencer
`timescale 1ns/1ps
module nv_store_recall_sequencer_tb;
  import nv_seq_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sup = 1'b1;
  logic        wr = 1'b0;
  logic        stp = 1'b0;
  logic        bsy = 1'b0;
  logic        req = 1'b0;
  logic [3:0]  len = 4'h1;
  soft_cmd_t   cmd = '0;
  logic        pin;
  logic        pout;
  logic        poe;
  seq_status_t st;
  int          miscompares = 0;
  int          compares = 0;
  initial forever #20 clk = ~clk;
  nv_store_recall_sequencer DUT (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_low_variant(1'b0), .i_supply_ok(sup), .i_sram_write(wr),
    .i_bus_stop(stp), .i_bus_busy(bsy), .i_cmd(cmd),
    .i_store_busy_pin_in(pin), .o_store_busy_pin_out(pout),
    .o_store_busy_pin_oe(poe), .o_status(st));
  store_busy_agent AGT (.i_clk_sys(clk), .i_req(req), .i_len(len),
    .i_dev_out(pout), .i_dev_oe(poe), .o_pin(pin));
  task check(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  function logic pick(input int s);
    return s == 0 ? st.busy : s == 1 ? st.access_en :
           s == 2 ? st.standby : st.asleep;
  endfunction : pick
  task await(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (pick(s) !== v)
    begin
      miscompares++;
      $display("mismatch at %0t: wait ran out", $time);
      conclude();
    end
  endtask : await
  task cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  task do_reset;
    @(negedge clk);
    rst = 1'b1;
    cycles(2);
    check(poe, 1'b0, "pin enabled in reset");
    check(st === 5'h00, 1'b1, "status in reset");
    rst = 1'b0;
    cycles(3);
  endtask : do_reset
  task pin_pull(input logic [3:0] n);
    len <= n;
    req <= 1'b1;
    cycles(1);
    req <= 1'b0;
  endtask : pin_pull
  task recall_lockout;
    cmd.soft_recall = 1'b1;
    cycles(1);
    cmd = '0;
    await(0, 1'b1, 12500);
    check(st.access_en, 1'b0, "access during recall");
    wr = 1'b1;
    cycles(1);
    wr = 1'b0;
    await(0, 1'b0, 15100);
    await(1, 1'b1, 20);
  endtask : recall_lockout
  task clean_pin;
    pin_pull(4'h6);
    cycles(4);
    check(st.access_en, 1'b0, "access while pin low");
    check(poe, 1'b0, "save without writes");
    await(1, 1'b1, 125);
    check(st.busy, 1'b0, "busy after clean event");
  endtask : clean_pin
  task standby;
    bsy = 1'b1;
    cycles(2);
    bsy = 1'b0;
    stp = 1'b1;
    cycles(1);
    stp = 1'b0;
    await(2, 1'b1, 2505);
    bsy = 1'b1;
    cycles(3);
    check(st.standby, 1'b0, "standby kept while busy");
    bsy = 1'b0;
  endtask : standby
  task sleep_entry;
    cmd.sleep = 1'b1;
    cycles(1);
    cmd = '0;
    await(3, 1'b1, 200005);
  endtask : sleep_entry
  task dirty_save;
    await(1, 1'b1, 20);
    wr = 1'b1;
    cycles(1);
    wr = 1'b0;
    cycles(2);
    pin_pull(4'h1);
    cycles(4);
    check(poe & ~pout, 1'b1, "pin not driven low");
    check(st.write_en, 1'b0, "writes open in save");
    check(st.access_en, 1'b0, "access open in save");
  endtask : dirty_save
  task supply_drop;
    sup = 1'b0;
    cycles(3);
    check(st.access_en, 1'b0, "access at low supply");
    check(poe, 1'b0, "save without writes");
  endtask : supply_drop
  initial
  begin
    do_reset();
    recall_lockout();
    clean_pin();
    standby();
    sleep_entry();
    do_reset();
    dirty_save();
    do_reset();
    supply_drop();
    conclude();
  end
endmodule : nv_store_recall_sequencer_tb
